//--- core/stc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - count is 16 bits in high and low bytes, both readable and writable
// - wrap from all ones to zero sets the overflow interrupt flag
// - compare unit special event trigger clears the whole count
// - control bit 0 lets the counter run when set, halts when clear
// - read-only bit 6 is 1 while system clock comes from our oscillator
// - prescale field bits 5:4, code 11 divides by 8, code 00 by 1
// - external source: bit 2 set bypasses sync, clear synchronizes
// - bit 1 picks external pin rising edges or oscillator divided by four
// - after fail-safe switch, clock status shows the real clock source
// - clock select 01 runs cpu and peripherals from our oscillator
module stc_timer
    import stc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire stc_pkg::stc_apb_req_s apb_req,
    output stc_pkg::stc_apb_rsp_s apb_rsp,
    input wire logic external_count_pin,
    input wire logic compare_unit_trigger,
    input wire logic fail_safe_switched,
    output logic timer_osc_run,
    output logic secondary_clock_run_mode,
    output logic irq
);
    import stc_pkg::*;

    stc_control_s ctl;
    logic [15:0] count;
    logic [7:0] high_buffer;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [1:0] system_clock_select;
    logic [2:0] pin_sync;
    logic pin_prev;
    logic pin_raw_prev;
    logic [1:0] int_div;
    logic [7:0] rd_byte;
    logic [31:0] rd_word;
    logic [31:0] prdata_q;
    logic [15:0] next_count;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    logic wr;
    logic rd;
    logic hit_ctl;
    logic hit_low;
    logic hit_high;
    logic hit_stat;
    logic hit_mask;
    logic hit_scs;
    logic ext_sync_edge;
    logic ext_raw_edge;
    logic src_tick;
    logic cnt_tick;
    logic overflow;
    logic clk_status;
    logic prescale_clear;

    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;
    assign hit_ctl = apb_req.paddr[11:0] == ADDR_CONTROL;
    assign hit_low = apb_req.paddr[11:0] == ADDR_COUNT_LOW;
    assign hit_high = apb_req.paddr[11:0] == ADDR_COUNT_HIGH;
    assign hit_stat = apb_req.paddr[11:0] == ADDR_IRQ_STATUS;
    assign hit_mask = apb_req.paddr[11:0] == ADDR_IRQ_MASK;
    assign hit_scs = apb_req.paddr[11:0] == ADDR_SYS_CLOCK;

    // three-stage synchroniser on the asynchronous count pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync <= 3'h0;
        end else begin
            pin_sync <= {pin_sync[1:0], external_count_pin};
        end
    end

    // filtered level only moves once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev <= 1'b0;
        end else if (pin_sync[2] == pin_sync[1]) begin
            pin_prev <= pin_sync[2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_raw_prev <= 1'b0;
        end else begin
            pin_raw_prev <= pin_sync[1];
        end
    end
    assign ext_sync_edge = (pin_sync[2] == pin_sync[1]) && pin_sync[2]
        && !pin_prev;
    // bypass path skips the agreement filter, saving a cycle of latency
    assign ext_raw_edge = pin_sync[1] && !pin_raw_prev;

    // internal count clock: oscillator divided by four
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_div <= 2'h0;
        end else begin
            int_div <= 2'(int_div + 2'h1);
        end
    end

    always_comb begin
        if (ctl.count_source_select) begin
            src_tick = ctl.external_sync_bypass ? ext_raw_edge
                : ext_sync_edge;
        end else begin
            src_tick = int_div == INT_DIV_LAST;
        end
    end

    // prescaler restarts on any control write so a new ratio starts clean
    assign prescale_clear = (wr && hit_ctl) || !ctl.count_run_enable;

    stc_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .clear(prescale_clear),
        .tick_in(src_tick && ctl.count_run_enable),
        .ratio({ctl.prescale_select_hi,
            ctl.prescale_select_lo}),
        .tick_out(cnt_tick)
    );

    assign overflow = cnt_tick && (count == COUNT_MAX);

    // count: trigger clear beats software write beats increment
    always_comb begin
        next_count = count;
        if (compare_unit_trigger) begin
            next_count = COUNT_ZERO;
        end else if (wr && hit_low) begin
            if (ctl.wide_access_select) begin
                next_count = {high_buffer, apb_req.pwdata[7:0]};
            end else begin
                next_count[7:0] = apb_req.pwdata[7:0];
            end
        end else if (wr && hit_high && !ctl.wide_access_select) begin
            next_count[15:8] = apb_req.pwdata[7:0];
        end else if (cnt_tick) begin
            next_count = 16'(count + 16'h1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= COUNT_ZERO;
        end else begin
            count <= next_count;
        end
    end

    // high buffer: filled by high writes, or by low reads in wide mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_buffer <= 8'h00;
        end else if (wr && hit_high) begin
            high_buffer <= apb_req.pwdata[7:0];
        end else if (rd && hit_low && ctl.wide_access_select) begin
            high_buffer <= count[15:8];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= CTL_RESET;
        end else begin
            if (wr && hit_ctl) begin
                ctl <= (apb_req.pwdata[7:0] & CTL_WMASK)
                    | ({7'h00, clk_status} << CTL_CLK_STAT);
            end else begin
                ctl.clock_from_timer_osc_status <= clk_status;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_clock_select <= SCS_PRIMARY;
        end else if (wr && hit_scs) begin
            system_clock_select <= apb_req.pwdata[1:0];
        end
    end

    assign timer_osc_run = ctl.timer_osc_enable;
    assign secondary_clock_run_mode =
        system_clock_select == SCS_SECONDARY;
    // monitor override shows the source really in use
    assign clk_status = secondary_clock_run_mode && ctl.timer_osc_enable
        && !fail_safe_switched;

    always_comb begin
        irq_set = '0;
        irq_set[IRQ_OVF] = overflow;
        irq_set[IRQ_SEV] = compare_unit_trigger;
    end
    assign irq_clr = (wr && hit_stat) ? apb_req.pwdata[IRQ_W-1:0] : '0;

    // sticky status: set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else begin
            irq_status <= irq_set | (irq_status & ~irq_clr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= '0;
        end else if (wr && hit_mask) begin
            irq_mask <= apb_req.pwdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    always_comb begin
        rd_byte = 8'h00;
        rd_word = 32'h0000_0000;
        if (hit_ctl) begin
            rd_word = {24'h000000, ctl};
        end else if (hit_low) begin
            rd_word = {24'h000000, count[7:0]};
        end else if (hit_high) begin
            // wide mode reads the buffered high byte
            rd_byte = ctl.wide_access_select ? high_buffer : count[15:8];
            rd_word = {24'h000000, rd_byte};
        end else if (hit_stat) begin
            rd_word = {30'h0, irq_status};
        end else if (hit_mask) begin
            rd_word = {30'h0, irq_mask};
        end else if (hit_scs) begin
            rd_word = {30'h0, system_clock_select};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
            prdata_q <= rd_word;
        end
    end

    // launched in setup so read data is settled through the access phase
    assign apb_rsp.prdata = prdata_q;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable
        && !(hit_ctl || hit_low || hit_high || hit_stat || hit_mask
        || hit_scs);
endmodule
`default_nettype wire

//--- core/stc_pkg.sv
package stc_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    // register byte addresses on the apb bus
    localparam logic [11:0] ADDR_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_COUNT_LOW = 12'h004;
    localparam logic [11:0] ADDR_COUNT_HIGH = 12'h008;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h00c;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
    localparam logic [11:0] ADDR_SYS_CLOCK = 12'h014;
    // control field positions
    localparam int unsigned CTL_RUN = 0;
    localparam int unsigned CTL_SRC = 1;
    localparam int unsigned CTL_SYNC_BYP = 2;
    localparam int unsigned CTL_OSC_EN = 3;
    localparam int unsigned CTL_PS_LO = 4;
    localparam int unsigned CTL_PS_HI = 5;
    localparam int unsigned CTL_CLK_STAT = 6;
    localparam int unsigned CTL_WIDE = 7;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CTL_WMASK = 8'hbf;
    // interrupt status bits
    localparam int unsigned IRQ_OVF = 0;
    localparam int unsigned IRQ_SEV = 1;
    localparam int unsigned IRQ_W = 2;
    // system clock select codes
    localparam logic [1:0] SCS_PRIMARY = 2'h0;
    localparam logic [1:0] SCS_SECONDARY = 2'h1;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    // internal clock is the oscillator divided by four
    localparam int unsigned INT_DIV = 4;
    localparam logic [1:0] INT_DIV_LAST = 2'(INT_DIV - 1);

    typedef struct packed {
        logic wide_access_select;
        logic clock_from_timer_osc_status;
        logic prescale_select_hi;
        logic prescale_select_lo;
        logic timer_osc_enable;
        logic external_sync_bypass;
        logic count_source_select;
        logic count_run_enable;
    } stc_control_s;

    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } stc_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } stc_apb_rsp_s;
endpackage

//--- core/stc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module stc_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic tick_in,
    input wire logic [1:0] ratio,
    output logic tick_out
);
    logic [2:0] cnt;
    logic [2:0] last;

    // ratio code n divides by 2^n
    assign last = 3'((4'h1 << ratio) - 4'h1);
    assign tick_out = tick_in && (cnt == last);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 3'h0;
        end else if (clear) begin
            cnt <= 3'h0;
        end else if (tick_in) begin
            cnt <= (cnt >= last) ? 3'h0 : 3'(cnt + 3'h1);
        end
    end
endmodule
`default_nettype wire

//--- sim/stc_ext_src.sv
`timescale 1ns/1ps
`default_nettype none
module stc_ext_src (
    input wire logic [7:0] n_edges,
    input wire logic go,
    output logic pin
);
    // the source is gated: the pin rests low between bursts
    initial pin = 1'b0;
    always @(posedge go) begin
        repeat (n_edges) begin
            #23 pin = 1'b1;
            #23 pin = 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- sim/stc_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module stc_timer_checker
    import stc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire stc_pkg::stc_apb_req_s apb_req,
    input wire stc_pkg::stc_apb_rsp_s apb_rsp,
    input wire logic external_count_pin,
    input wire logic compare_unit_trigger,
    input wire logic fail_safe_switched,
    input wire logic timer_osc_run,
    input wire logic secondary_clock_run_mode,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence acc(logic [11:0] a, logic w);
        apb_req.psel && apb_req.penable && apb_req.pwrite == w
            && apb_req.paddr == {20'h0, a};
    endsequence
    sequence on_sec;
        secondary_clock_run_mode && timer_osc_run && !fail_safe_switched;
    endsequence
    osc_run_a:
    assert property (acc(ADDR_CONTROL, 1'b1)
        |=> timer_osc_run == $past(apb_req.pwdata[CTL_OSC_EN]))
        else $error("oscillator run output wrong");
    sec_mode_a:
    assert property (acc(ADDR_SYS_CLOCK, 1'b1) |=> secondary_clock_run_mode
        == ($past(apb_req.pwdata[1:0]) == SCS_SECONDARY))
        else $error("secondary mode output wrong");
    mask_off_a:
    assert property (acc(ADDR_IRQ_MASK, 1'b1)
        ##0 apb_req.pwdata[1:0] == 2'h0 |=> !irq)
        else $error("irq high with all masked");
    reset_out_a:
    assert property ($rose(presetn)
        |-> !timer_osc_run && !secondary_clock_run_mode && !irq)
        else $error("outputs not cleared by reset");
    one_wait_a:
    assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready
        && apb_rsp.pslverr == (apb_req.paddr[11:0] > ADDR_SYS_CLOCK))
        else $error("access phase not answered");
    stat_zero_a:
    assert property ((!(secondary_clock_run_mode && timer_osc_run))[*3] ##1
        acc(ADDR_CONTROL, 1'b0) |-> !apb_rsp.prdata[CTL_CLK_STAT])
        else $error("clock status set without source");
    stat_fs_a:
    assert property (fail_safe_switched[*3] ##1 acc(ADDR_CONTROL, 1'b0)
        |-> !apb_rsp.prdata[CTL_CLK_STAT])
        else $error("clock status set after fail safe");
    stat_one_a:
    assert property (on_sec[*3] ##1 acc(ADDR_CONTROL, 1'b0)
        |-> apb_rsp.prdata[CTL_CLK_STAT])
        else $error("clock status clear on secondary");
endmodule
bind stc_timer stc_timer_checker i_chk (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp),
    .external_count_pin(external_count_pin),
    .compare_unit_trigger(compare_unit_trigger),
    .fail_safe_switched(fail_safe_switched), .timer_osc_run(timer_osc_run),
    .secondary_clock_run_mode(secondary_clock_run_mode), .irq(irq));
`default_nettype wire

//--- sim/sixteen_bit_timer_counter_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sixteen_bit_timer_counter_bench;
    import stc_pkg::*;
    logic pclk = 0, presetn = 0, trig = 0, fss = 0, go = 0;
    logic [7:0] n_ext = 0;
    wire logic pin;
    logic osc, sec, irq;
    stc_apb_req_s req = '0;
    stc_apb_rsp_s rsp;
    logic [15:0] q[$];
    int n_fail = 0, total_checks = 0;
    always #5 pclk = ~pclk;
    stc_timer i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .external_count_pin(pin),
        .compare_unit_trigger(trig), .fail_safe_switched(fss),
        .timer_osc_run(osc), .secondary_clock_run_mode(sec), .irq(irq));
    stc_ext_src i_src (.n_edges(n_ext), .go(go), .pin(pin));
    task automatic check(input string nm, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic [11:0] a, logic w, logic [31:0] d);
        @(posedge pclk);
        req.paddr <= {20'h0, a};
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'b1;
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1) @(posedge pclk);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rd(input logic [11:0] a, logic [7:0] e, t = 8'h0);
        q.push_back({t, e});
        apb(a, 1'b0, 32'h0);
    endtask
    // counts are only known to one tick because the divider phase is hidden
    always @(posedge pclk) begin
        logic [15:0] e;
        logic [7:0] s;
        logic unmapped;
        if (req.psel && req.penable && rsp.pready === 1'b1) begin
            unmapped = req.paddr[11:0] > ADDR_SYS_CLOCK;
            check("slverr", {7'h0, rsp.pslverr}, {7'h0, unmapped});
            if (!req.pwrite) begin
                e = q.pop_front();
                s = rsp.prdata[7:0] - e[7:0] + e[15:8];
                if (e[15:8] == 8'h0) begin
                    check("read", rsp.prdata[7:0], e[7:0]);
                end else begin
                    check("count", {7'h0, s <= 2 * e[15:8]}, 8'h1);
                end
            end
        end
    end
    initial begin
        logic [15:0] v;
        void'($urandom(32'ha140));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_CONTROL, 8'h00);
        wr(ADDR_CONTROL, 32'hff);
        rd(ADDR_CONTROL, 8'hbf);
        wr(ADDR_CONTROL, 32'h0);
        #1 check("osc", {7'h0, osc}, 8'h0);
        v = 16'($urandom());
        wr(ADDR_COUNT_LOW, {24'h0, v[7:0]});
        wr(ADDR_COUNT_HIGH, {24'h0, v[15:8]});
        repeat (40) @(posedge pclk);
        rd(ADDR_COUNT_LOW, v[7:0]);
        rd(ADDR_COUNT_HIGH, v[15:8]);
        trig <= 1'b1;
        @(posedge pclk);
        trig <= 1'b0;
        rd(ADDR_COUNT_HIGH, 8'h00);
        rd(ADDR_IRQ_STATUS, 8'h02);
        wr(ADDR_IRQ_STATUS, 32'h3);
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_COUNT_LOW, 32'h0);
            wr(ADDR_CONTROL, 32'h1 | (p << 4));
            repeat (64 << p) @(posedge pclk);
            wr(ADDR_CONTROL, 32'h0);
            rd(ADDR_COUNT_LOW, 8'd16, 8'd1);
        end
        wr(ADDR_IRQ_MASK, 32'h1);
        wr(ADDR_COUNT_LOW, 32'hfe);
        wr(ADDR_COUNT_HIGH, 32'hff);
        wr(ADDR_CONTROL, 32'h1);
        repeat (20) @(posedge pclk);
        wr(ADDR_CONTROL, 32'h0);
        #1 check("irq", {7'h0, irq}, 8'h1);
        rd(ADDR_COUNT_HIGH, 8'h00);
        rd(ADDR_IRQ_STATUS, 8'h01);
        wr(ADDR_IRQ_MASK, 32'h0);
        #1 check("irq", {7'h0, irq}, 8'h0);
        for (int s = 0; s < 2; s++) begin
            wr(ADDR_COUNT_LOW, 32'h0);
            wr(ADDR_CONTROL, 32'h3 | (s << 2));
            n_ext <= 8'($urandom_range(20, 5));
            go <= 1'b1;
            @(posedge pclk);
            go <= 1'b0;
            repeat (200) @(posedge pclk);
            wr(ADDR_CONTROL, 32'h0);
            rd(ADDR_COUNT_LOW, n_ext);
        end
        wr(ADDR_CONTROL, 32'h80);
        wr(ADDR_COUNT_HIGH, 32'hab);
        wr(ADDR_COUNT_LOW, 32'hcd);
        wr(ADDR_COUNT_HIGH, 32'h11);
        rd(ADDR_COUNT_LOW, 8'hcd);
        rd(ADDR_COUNT_HIGH, 8'hab);
        wr(ADDR_SYS_CLOCK, 32'h1);
        wr(ADDR_CONTROL, 32'h08);
        #1 check("secondary", {7'h0, sec}, 8'h1);
        repeat (2) @(posedge pclk);
        rd(ADDR_CONTROL, 8'h48);
        fss <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(ADDR_CONTROL, 8'h08);
        fss <= 1'b0;
        rd(12'h040, 8'h00);
        report_and_stop();
    end
    initial begin
        #100us;
        n_fail++;
        report_and_stop();
    end
endmodule
`default_nettype wire
